// ===== src/ugr_defs.svh
`ifndef UGR_DEFS_SVH
`define UGR_DEFS_SVH

// register addresses on the parallel bus
`define UGR_ADDR_INT_STATUS     8'h18
`define UGR_ADDR_INT_ENABLE     8'h14
`define UGR_ADDR_CHIP_IDENTITY  8'h70
`define UGR_ADDR_FRAME_NUMBER   8'h74
`define UGR_ADDR_SCRATCH        8'h78

// interrupt status bit positions
`define UGR_BIT_BUS_RESET       0
`define UGR_BIT_SOF             1
`define UGR_BIT_PSEUDO_SOF      2
`define UGR_BIT_SUSPEND         3
`define UGR_BIT_RESUME          4
`define UGR_BIT_HIGH_SPEED      5
`define UGR_BIT_DMA             6
`define UGR_BIT_VBUS            7
`define UGR_BIT_SETUP           8
`define UGR_BIT_CTRL_RX         10

// implemented interrupt bits (bit 9 reserved)
`define UGR_INT_MASK            16'h05ff

// reset values
`define UGR_FRAME_RESET         16'h0000
`define UGR_SCRATCH_RESET       16'h0000
`define UGR_INT_RESET           16'h0000

// frame number field positions
`define UGR_FRAME_LSB           0
`define UGR_FRAME_MSB           10
`define UGR_MICRO_LSB           11
`define UGR_MICRO_MSB           13

// timing, clock period and figures in ns
`define UGR_CLK_PERIOD_NS       10
`define UGR_PSEUDO_FRAME_TICK_FLAG_FS_NS          1000000
`define UGR_PSEUDO_FRAME_TICK_FLAG_HS_NS          125000
`define UGR_SE0_OTG_NS          2000000
`define UGR_PSEUDO_FRAME_TICK_FLAG_FS_CYCLES      (`UGR_PSEUDO_FRAME_TICK_FLAG_FS_NS / `UGR_CLK_PERIOD_NS)
`define UGR_PSEUDO_FRAME_TICK_FLAG_HS_CYCLES      (`UGR_PSEUDO_FRAME_TICK_FLAG_HS_NS / `UGR_CLK_PERIOD_NS)
`define UGR_SE0_OTG_CYCLES      ((`UGR_SE0_OTG_NS + `UGR_CLK_PERIOD_NS - 1) / `UGR_CLK_PERIOD_NS)

`endif

// ===== src/ugr_general_regs.sv
// Notes on behaviour
// RULE_01 - control rx buffer event sets bit 10
// RULE_02 - setup token sets bit 8
// RULE_03 - vbus rising edge sets bit 7
// RULE_04 - dma reason change sets bit 6
// RULE_05 - full to high speed sets bit 5
// RULE_06 - suspend to active sets bit 4
// RULE_07 - active to suspend sets bit 3
// RULE_08 - free pseudo frame tick sets bit 2
// RULE_09 - received frame start sets bit 1
// RULE_10 - bus reset sets bit 0
// RULE_11 - otg mode: bit 0 reports 2 ms se0
// RULE_12 - read-only identity: chip_identity and version; reads give only chip_identity[15:0], without CHIP_IDENTITY[15:8]
// RULE_13 - firmware checks identity before using features
// RULE_14 - frame and microframe number read-only
// RULE_15 - byte reads return low byte first
// RULE_16 - plain read-write 16-bit scratch register
// RULE_17 - write one clears each status bit
// RULE_18 - dma flag cleared after reason cleared
// RULE_19 - interrupt asserted while enabled bit set
// RULE_20 - frame and scratch zero after resets
`timescale 1ns/1ps
`default_nettype none
`include "ugr_defs.svh"
module ugr_general_regs #(
    parameter logic [15:0] CHIP_IDENTITY      = 16'h00a5, // arbitrary value
    parameter logic [7:0]  CHIP_VERSION = 8'h01,    // arbitrary value
    parameter int          PSEUDO_FRAME_TICK_FLAG_FS_CYCLES = `UGR_PSEUDO_FRAME_TICK_FLAG_FS_CYCLES,
    parameter int          PSEUDO_FRAME_TICK_FLAG_HS_CYCLES = `UGR_PSEUDO_FRAME_TICK_FLAG_HS_CYCLES,
    parameter int          SE0_CYCLES     = `UGR_SE0_OTG_CYCLES
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    // parallel register port
    input  wire ugr_pkg::ugr_addr_t addr,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    input  wire logic             bus_8bit,
    input  wire ugr_pkg::ugr_word_t wdata,
    output ugr_pkg::ugr_word_t    rdata,
    output logic                  rvalid,
    // enable register value from the rest of the chip
    input  wire logic [31:0]      int_enable,
    input  wire logic             otg_enable,
    // events from the link and core logic
    input  wire logic             ctrl_ep_rx_event,
    input  wire logic             ctrl_setup_event,
    input  wire logic             vbus_pin,
    input  wire logic             dma_reason_changed,
    input  wire logic             dma_reason_pending,
    input  wire logic             high_speed,
    input  wire logic             bus_suspended,
    input  wire logic             sof_valid,
    input  wire logic [10:0]      sof_frame,
    input  wire logic [2:0]       sof_micro,
    input  wire logic             bus_reset_event,
    input  wire logic             se0_pin,
    // status out
    output logic [15:0]           interrupt_status,
    output logic                  int_out,
    output logic                  usb_reset_seen
);
    import ugr_pkg::*;

    logic [1:0]  vbus_sync;
    logic [1:0]  se0_sync;
    logic        vbus_prev;
    logic        hs_prev;
    logic        suspend_flag_prev;
    logic        pseudo_tick;
    logic        se0_held;
    logic        bus_reset_int;
    logic [15:0] set_bits;
    logic [15:0] clear_bits;
    logic [15:0] frame_number;
    logic [15:0] firmware_scratch;
    logic [23:0] chip_identity;
    logic        byte_phase;
    logic [15:0] read_word;
    logic        hit_status;
    logic        hit_frame;
    logic        hit_scratch;
    logic        hit_ident;
    logic [15:0] lane_data;
    wire  logic [15:0] next_status;

    localparam logic [15:0] INT_MASK = `UGR_INT_MASK;

    assign chip_identity = {CHIP_IDENTITY, CHIP_VERSION}; // RULE_12

    // pin inputs pass two flip-flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vbus_sync <= 2'b00;
            se0_sync  <= 2'b00;
        end else begin
            vbus_sync <= {vbus_sync[0], vbus_pin};
            se0_sync  <= {se0_sync[0], se0_pin};
        end
    end

    // previous levels for edge detection
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vbus_prev <= 1'b0;
            hs_prev   <= 1'b0;
            suspend_flag_prev <= 1'b0;
        end else begin
            vbus_prev <= vbus_sync[1];
            hs_prev   <= high_speed;
            suspend_flag_prev <= bus_suspended;
        end
    end

    ugr_pseudo_frame #(
        .FS_CYCLES (PSEUDO_FRAME_TICK_FLAG_FS_CYCLES),
        .HS_CYCLES (PSEUDO_FRAME_TICK_FLAG_HS_CYCLES)
    ) u_pseudo (
        .core_clk   (core_clk),
        .reset      (reset),
        .high_speed (high_speed),
        .tick       (pseudo_tick)
    );

    ugr_se0_timer #(
        .HOLD_CYCLES (SE0_CYCLES)
    ) u_se0 (
        .core_clk (core_clk),
        .reset    (reset),
        .se0      (se0_sync[1]),
        .held     (se0_held)
    );

    // in otg mode bit 0 reports long se0 instead of bus reset
    assign bus_reset_int = otg_enable ? se0_held : bus_reset_event; // RULE_11
    assign usb_reset_seen = bus_reset_event;

    // hardware set conditions for each status bit
    always_comb begin
        set_bits = 16'h0000;
        set_bits[`UGR_BIT_CTRL_RX]    = ctrl_ep_rx_event;                 // RULE_01
        set_bits[`UGR_BIT_SETUP]      = ctrl_setup_event;                 // RULE_02
        set_bits[`UGR_BIT_VBUS]       = vbus_sync[1] && !vbus_prev;       // RULE_03
        set_bits[`UGR_BIT_DMA]        = dma_reason_changed;               // RULE_04
        set_bits[`UGR_BIT_HIGH_SPEED] = high_speed && !hs_prev;           // RULE_05
        set_bits[`UGR_BIT_RESUME]     = suspend_flag_prev && !bus_suspended;      // RULE_06
        set_bits[`UGR_BIT_SUSPEND]    = bus_suspended && !suspend_flag_prev;      // RULE_07
        set_bits[`UGR_BIT_PSEUDO_SOF] = pseudo_tick;                      // RULE_08
        set_bits[`UGR_BIT_SOF]        = sof_valid;                        // RULE_09
        set_bits[`UGR_BIT_BUS_RESET]  = bus_reset_int;                    // RULE_10
    end

    // address decode
    assign hit_status  = (addr == `UGR_ADDR_INT_STATUS);
    assign hit_frame   = (addr == `UGR_ADDR_FRAME_NUMBER);
    assign hit_scratch = (addr == `UGR_ADDR_SCRATCH);
    assign hit_ident   = (addr == `UGR_ADDR_CHIP_IDENTITY);

    // write data lane: on an 8-bit bus the byte lands in the half picked by phase
    always_comb begin
        lane_data = wdata;
        if (bus_8bit) begin
            lane_data = byte_phase ? {wdata[7:0], 8'h00} : {8'h00, wdata[7:0]};
        end
    end

    // write-one-to-clear; dma bit holds while a reason is pending
    always_comb begin
        clear_bits = 16'h0000;
        if (wr_en && hit_status) begin
            clear_bits = lane_data & INT_MASK;                            // RULE_17
            if (dma_reason_pending) begin
                clear_bits[`UGR_BIT_DMA] = 1'b0;                          // RULE_18
            end
        end
    end

    // next value per flag: a new event wins over a clear, absent bits stay zero
    for (genvar b = 0; b < 16; b++) begin : g_status
        if (INT_MASK[b]) begin : g_used
            assign next_status[b] = set_bits[b]                           // RULE_17
                                    || (interrupt_status[b] && !clear_bits[b]);
        end else begin : g_unused
            assign next_status[b] = 1'b0;
        end
    end

    // status register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            interrupt_status <= `UGR_INT_RESET;
        end else begin
            interrupt_status <= next_status;                              // RULE_17
        end
    end

    // interrupt line from enabled status bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            int_out <= 1'b0;
        end else begin
            int_out <= |(interrupt_status & int_enable[15:0]);            // RULE_19
        end
    end

    // frame number loads only on valid frame start; reset and bus reset clear it
    always_ff @(posedge core_clk) begin
        if (reset || bus_reset_event) begin
            frame_number <= `UGR_FRAME_RESET;                             // RULE_20
        end else if (sof_valid) begin
            frame_number <= {2'b00, sof_micro, sof_frame};                // RULE_14
        end
    end

    // scratch storage, no side effects
    always_ff @(posedge core_clk) begin
        if (reset || bus_reset_event) begin
            firmware_scratch <= `UGR_SCRATCH_RESET;                       // RULE_20
        end else if (wr_en && hit_scratch) begin
            if (bus_8bit) begin
                if (byte_phase) begin
                    firmware_scratch[15:8] <= wdata[7:0];
                end else begin
                    firmware_scratch[7:0] <= wdata[7:0];
                end
            end else begin
                firmware_scratch <= wdata;                                // RULE_16
            end
        end
    end

    // byte phase on 8-bit bus: low byte first, then high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            byte_phase <= 1'b0;
        end else if (!bus_8bit) begin
            byte_phase <= 1'b0;
        end else if (rd_en || wr_en) begin
            byte_phase <= !byte_phase;                                    // RULE_15
        end
    end

    // read mux
    always_comb begin
        read_word = 16'h0000;
        if (hit_status) begin
            read_word = interrupt_status;
        end else if (hit_frame) begin
            read_word = frame_number;
        end else if (hit_scratch) begin
            read_word = firmware_scratch;
        end else if (hit_ident) begin
            read_word = chip_identity[15:0];
        end
    end

    // registered read data, byte lane chosen by phase
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata  <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_en;
            if (rd_en) begin
                if (bus_8bit) begin
                    rdata <= byte_phase ? {8'h00, read_word[15:8]}
                                        : {8'h00, read_word[7:0]};        // RULE_15
                end else begin
                    rdata <= read_word;
                end
            end
        end
    end
endmodule : ugr_general_regs
`default_nettype wire

// ===== src/ugr_pkg.sv
package ugr_pkg;
    typedef logic [15:0] ugr_word_t;
    typedef logic [7:0]  ugr_addr_t;
    // lane selection for an access
    typedef enum logic [1:0] {
        UGR_LANE_WORD,
        UGR_LANE_LOW,
        UGR_LANE_HIGH
    } ugr_lane_t;
endpackage : ugr_pkg

// ===== src/ugr_pseudo_frame.sv
`timescale 1ns/1ps
`default_nettype none
module ugr_pseudo_frame #(
    parameter int FS_CYCLES = 100000,
    parameter int HS_CYCLES = 12500
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic high_speed,
    output logic      tick
);
    import ugr_pkg::*;

    logic [31:0] count;
    logic [31:0] limit;

    assign limit = high_speed ? 32'(HS_CYCLES - 1) : 32'(FS_CYCLES - 1);

    // free-running period counter, not aligned to bus frames
    always_ff @(posedge core_clk) begin
        if (reset) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule : ugr_pseudo_frame
`default_nettype wire

// ===== src/ugr_se0_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ugr_se0_timer #(
    parameter int HOLD_CYCLES = 200000
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic se0,
    output logic      held
);
    import ugr_pkg::*;

    logic [31:0] count;

    // one pulse once se0 has lasted the hold time
    always_ff @(posedge core_clk) begin
        if (reset || !se0) begin
            count <= 32'h0000_0000;
            held  <= 1'b0;
        end else if (count == 32'(HOLD_CYCLES - 1)) begin
            count <= count + 32'h0000_0001;
            held  <= 1'b1;
        end else if (count < 32'(HOLD_CYCLES)) begin
            count <= count + 32'h0000_0001;
            held  <= 1'b0;
        end else begin
            held  <= 1'b0;
        end
    end
endmodule : ugr_se0_timer
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ugr_pkg::*;
    localparam logic [15:0] CID = 16'h5a3c; // arbitrary value
    localparam logic [7:0]  VER = 8'h07;    // arbitrary value
    localparam ugr_word_t   M   = 16'hfffb; // free tick bit masked
    logic core_clk, reset, wr_en, rd_en, bus_8bit, rvalid, int_out, otg_enable;
    logic vbus_pin, high_speed, bus_suspended, dma_reason_pending, se0_pin;
    logic [10:0] ev, sof_frame;
    logic [2:0]  sof_micro;
    logic [31:0] int_enable;
    ugr_addr_t addr;
    ugr_word_t wdata, rdata, d;
    int errors, compares, cycles;
    int order[7] = '{10, 8, 7, 5, 3, 4, 1};
    ugr_host_model ugr_host_model_inst (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid),
        .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata));
    ugr_general_regs #(.CHIP_IDENTITY(CID), .CHIP_VERSION(VER), .PSEUDO_FRAME_TICK_FLAG_FS_CYCLES(100),
        .PSEUDO_FRAME_TICK_FLAG_HS_CYCLES(20), .SE0_CYCLES(50)) ugr_general_regs_inst (
        .core_clk(core_clk), .reset(reset), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .bus_8bit(bus_8bit), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
        .int_enable(int_enable), .otg_enable(otg_enable), .ctrl_ep_rx_event(ev[10]),
        .ctrl_setup_event(ev[8]), .vbus_pin(vbus_pin), .dma_reason_changed(ev[6]),
        .dma_reason_pending(dma_reason_pending), .high_speed(high_speed),
        .bus_suspended(bus_suspended), .sof_valid(ev[1]), .sof_frame(sof_frame),
        .sof_micro(sof_micro), .bus_reset_event(ev[0]), .se0_pin(se0_pin),
        .interrupt_status(), .int_out(int_out), .usb_reset_seen());
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input ugr_word_t got, input ugr_word_t exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input ugr_addr_t a, input ugr_word_t exp, input ugr_word_t m);
        ugr_host_model_inst.rd(a, d);
        chk(d & m, exp);
    endtask : rdc
    // one event: pulse or level change
    task automatic raise(input int i);
        @(posedge core_clk);
        case (i)
            3: bus_suspended <= 1'b1;
            4: bus_suspended <= 1'b0;
            5: high_speed <= 1'b1;
            7: vbus_pin <= 1'b1;
            default: ev[i] <= 1'b1;
        endcase
        @(posedge core_clk);
        ev <= '0;
        repeat (4) @(posedge core_clk);
    endtask : raise
    initial begin
        {reset, bus_8bit, otg_enable, vbus_pin, high_speed} = 5'b10000;
        {bus_suspended, dma_reason_pending, se0_pin, ev, int_enable} = '0;
        {sof_micro, sof_frame} = 14'h35a5;
        {errors, compares, cycles} = '0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rdc(8'h18, 16'h0000, M);
        ugr_host_model_inst.wr(8'h70, 16'hffff);
        rdc(8'h70, {CID[7:0], VER}, 16'hffff);
        rdc(8'h40, 16'h0000, 16'hffff);
        rdc(8'h74, 16'h0000, 16'hffff);
        ugr_host_model_inst.wr(8'h78, 16'hc3e1);
        rdc(8'h78, 16'hc3e1, 16'hffff);
        foreach (order[k]) begin
            raise(order[k]);
            rdc(8'h18, 16'h0001 << order[k], M);
            ugr_host_model_inst.wr(8'h18, 16'h0001 << order[k]);
            rdc(8'h18, 16'h0000, M);
        end
        {sof_micro, sof_frame} <= 14'h08ff;
        ugr_host_model_inst.wr(8'h74, 16'h0000);
        @(posedge core_clk) bus_8bit <= 1'b1;
        rdc(8'h74, 16'h00a5, 16'h00ff);
        rdc(8'h74, 16'h0035, 16'h00ff);
        ugr_host_model_inst.wr(8'h78, 16'h0011);
        ugr_host_model_inst.wr(8'h78, 16'h0022);
        raise(8);
        ugr_host_model_inst.wr(8'h18, 16'h0000);
        ugr_host_model_inst.wr(8'h18, 16'h0001);
        @(posedge core_clk) bus_8bit <= 1'b0;
        rdc(8'h74, 16'h35a5, 16'hffff);
        rdc(8'h78, 16'h2211, 16'hffff);
        rdc(8'h18, 16'h0000, M);
        raise(0);
        rdc(8'h18, 16'h0001, M);
        rdc(8'h74, 16'h0000, 16'hffff);
        rdc(8'h78, 16'h0000, 16'hffff);
        ugr_host_model_inst.wr(8'h18, 16'h0001);
        @(posedge core_clk) otg_enable <= 1'b1;
        raise(0);
        rdc(8'h18, 16'h0000, M);
        @(posedge core_clk) se0_pin <= 1'b1;
        repeat (60) @(posedge core_clk);
        rdc(8'h18, 16'h0001, M);
        se0_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        ugr_host_model_inst.wr(8'h18, 16'h0001);
        dma_reason_pending <= 1'b1;
        raise(6);
        ugr_host_model_inst.wr(8'h18, 16'h0040);
        rdc(8'h18, 16'h0040, M);
        dma_reason_pending <= 1'b0;
        ugr_host_model_inst.wr(8'h18, 16'h0040);
        rdc(8'h18, 16'h0000, M);
        int_enable <= 32'h0000_0100;
        raise(8);
        chk({15'h0000, int_out}, 16'h0001);
        ugr_host_model_inst.wr(8'h18, 16'h0100);
        repeat (2) @(posedge core_clk);
        #1;
        chk({15'h0000, int_out}, 16'h0000);
        ugr_host_model_inst.wr(8'h18, 16'h0004);
        repeat (25) @(posedge core_clk);
        rdc(8'h18, 16'h0004, 16'h0004);
        ugr_host_model_inst.wr(8'h78, 16'h5a5a);
        {high_speed, vbus_pin, reset} <= 3'b001;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdc(8'h18, 16'h0000, 16'hffff);
        rdc(8'h78, 16'h0000, 16'hffff);
        repeat (50) @(posedge core_clk);
        rdc(8'h18, 16'h0000, 16'h0004);
        repeat (50) @(posedge core_clk);
        rdc(8'h18, 16'h0004, 16'h0004);
        close_out();
    end
endmodule : tb_top
`default_nettype wire

// ===== verification/ugr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ugr_checker (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire ugr_pkg::ugr_addr_t addr,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire logic               bus_8bit,
    input wire ugr_pkg::ugr_word_t wdata,
    input wire logic               rvalid,
    input wire logic [31:0]        int_enable,
    input wire logic               otg_enable,
    input wire logic               ctrl_ep_rx_event,
    input wire logic               ctrl_setup_event,
    input wire logic               vbus_pin,
    input wire logic               sof_valid,
    input wire logic               bus_reset_event,
    input wire logic               usb_reset_seen,
    input wire logic [15:0]        interrupt_status,
    input wire logic               int_out
);
    import ugr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // a lone read and its single answer pulse
    sequence s_lone_read;
        rd_en ##1 !rd_en;
    endsequence
    sequence s_one_answer;
        rvalid ##1 !rvalid;
    endsequence
    a_read_answer: assert property (s_lone_read |-> s_one_answer)
        else $error("read answer pulse wrong");
    a_no_stray: assert property (!rd_en |=> !rvalid)
        else $error("answer without read");
    a_rx_flag: assert property (ctrl_ep_rx_event |=> interrupt_status[10])
        else $error("rx flag not set");
    a_reserved_zero: assert property (!interrupt_status[9])
        else $error("reserved bit set");
    a_setup_flag: assert property (ctrl_setup_event |=> interrupt_status[8])
        else $error("setup flag not set");
    a_vbus_flag: assert property ($rose(vbus_pin) |-> ##[1:4] interrupt_status[7])
        else $error("vbus flag late");
    a_frame_flag: assert property (sof_valid |=> interrupt_status[1])
        else $error("frame flag not set");
    a_bus_reset: assert property (bus_reset_event && !otg_enable |=> interrupt_status[0])
        else $error("bus reset flag not set");
    a_w1c_clear: assert property (wr_en && addr == 8'h18 && !bus_8bit && wdata[8]
        && !ctrl_setup_event |=> !interrupt_status[8])
        else $error("setup flag not cleared");
    a_reset_mirror: assert property (usb_reset_seen == bus_reset_event)
        else $error("reset indication wrong");
    a_int_level: assert property (1'b1 |=> int_out ==
        |($past(interrupt_status) & $past(int_enable[15:0])))
        else $error("interrupt output wrong");
endmodule : ugr_checker
bind ugr_general_regs ugr_checker ugr_checker_inst (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .bus_8bit(bus_8bit), .wdata(wdata), .rvalid(rvalid), .int_enable(int_enable),
    .otg_enable(otg_enable), .ctrl_ep_rx_event(ctrl_ep_rx_event),
    .ctrl_setup_event(ctrl_setup_event), .vbus_pin(vbus_pin), .sof_valid(sof_valid),
    .bus_reset_event(bus_reset_event), .usb_reset_seen(usb_reset_seen),
    .interrupt_status(interrupt_status),
    .int_out(int_out)
);
`default_nettype wire

// ===== verification/ugr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ugr_host_model (
    input  wire logic               core_clk,
    input  wire ugr_pkg::ugr_word_t rdata,
    input  wire logic               rvalid,
    output ugr_pkg::ugr_addr_t      addr,
    output logic                    wr_en,
    output logic                    rd_en,
    output ugr_pkg::ugr_word_t      wdata
);
    import ugr_pkg::*;
    // bus idle at time zero
    initial begin
        addr = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = '0;
    end
    // one write strobe; data scrambled once the strobe is gone
    task automatic wr(input ugr_addr_t a, input ugr_word_t d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask : wr
    // one read strobe; answer taken at the edge where rvalid is seen high
    task automatic rd(input ugr_addr_t a, output ugr_word_t d);
        d = 'x;
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(posedge core_clk);
        if (rvalid === 1'b1) d = rdata;
    endtask : rd
endmodule : ugr_host_model
`default_nettype wire
